// ==== rcr_calendar_monitor.sv ====
// concurrent checks on the calendar register block ports
// assumes it is bound into every rcr_calendar_regs instance
`timescale 1ns/10ps
`default_nettype none
`include "rcr_defines.svh"
module rcr_calendar_monitor
    import rcr_pkg::*;
(
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              bkp_reset,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic [2:0]        hsize,
    input wire logic [31:0]       hwdata,
    input wire logic              hready,
    input wire logic [31:0]       hrdata,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire rcr_pkg::rcr_cal_t cal_now,
    input wire rcr_pkg::rcr_cal_t shadow_cal,
    input wire logic              second_tick,
    input wire logic              add_second,
    input wire logic              alarm_occurred_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset || bkp_reset);
    logic stat_wr;
    logic rd_take;
    // status write and read address phases taken by the slave
    assign stat_wr = hsel & htrans[1] & hready & hwrite & (haddr[7:0] == `RCR_STAT_OFS);
    assign rd_take = hsel & htrans[1] & hready & ~hwrite;
    sequence s_psc_first_rd;
        $past(bkp_reset) && rd_take && haddr[7:0] == `RCR_PSC_OFS;
    endsequence
    sequence s_alarm_clr;
        stat_wr && hsize == 3'b010 ##1 !hwdata[`RCR_ST_ALMF];
    endsequence
    a_ready_high: assert property (hreadyout)
        else $error("hreadyout low");
    a_resp_okay: assert property (!hresp)
        else $error("hresp not okay");
    a_rdata_idle: assert property (!rd_take |=> hrdata == 32'h0)
        else $error("hrdata not zero after non-read cycle");
    a_psc_reset: assert property (s_psc_first_rd |=> hrdata == `RCR_PSC_RST)
        else $error("prescaler reset value wrong");
    a_alarm_clear: assert property (s_alarm_clr |=> !alarm_occurred_flag)
        else $error("alarm flag not cleared");
    a_flag_cause: assert property ($fell(alarm_occurred_flag) && !$past(bkp_reset)
        |-> $past(stat_wr, 2))
        else $error("alarm flag fell without status write");
    a_tick_pulse: assert property (second_tick |=> !second_tick)
        else $error("second tick longer than one cycle");
    a_add_pulse: assert property (add_second |=> !add_second)
        else $error("add second pulse longer than one cycle");
    a_shadow_copy: assert property ($changed(shadow_cal) |->
        (shadow_cal == $past(cal_now)) || $past(reset) || $past(bkp_reset))
        else $error("shadow copy differs from calendar");
endmodule
bind rcr_calendar_regs rcr_calendar_monitor u_mon (.clk(clk), .reset(reset),
    .bkp_reset(bkp_reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cal_now(cal_now), .shadow_cal(shadow_cal), .second_tick(second_tick),
    .add_second(add_second), .alarm_occurred_flag(alarm_occurred_flag));
`default_nettype wire

// ==== rcr_calendar_regs.sv ====
// calendar register block: prescalers, alarm compare, write key, shift,
// time stamp capture and smooth calibration behind an AHB-Lite slave
// assumes the calendar counters sit outside and are on clk
`timescale 1ns/10ps
`default_nettype none
`include "rcr_defines.svh"
// Overview of operation
// - alarm-writable flag is high when alarm is disabled or in init state
// - shift writes refused while shift pending; pending stays until applied
// - prescaler written only in init and unlocked; backup reset 0x007f00ff
// - async tick = source clock divided by async factor plus one
// - second tick = async tick divided by sync factor plus one
// - each alarm field group has a mask excluding it from compare
// - weekday select makes day units a weekday, day tens ignored
// - alarm register holds BCD fields and PM bit at fixed positions
// - alarm register protected, written in init, backup reset zero
// - key register takes 8-bit keys in word writes to unlock
// - sub-second register reads the sync down-counter
// - system reset clears sub-second counter unless bypass is set
// - shift fraction is added to the sync down-counter
// - add-one-second with fraction advances calendar by one second
// - any shift register write clears the shadow synced flag unless a shadow copy is set in that cycle
// - time stamp captures time; clearing the flag clears it
// - time stamp captures date; clearing the flag clears it
// - time stamp captures sub-second count; flag clear clears it
// - frequency increase inserts one source pulse every 2048
// - net pulses over window equal 512 times increase minus mask count
// - 8 s window forces two low mask bits to zero
// - calibration pending set on write outside init, cleared at window
// - mask count removes that many pulses per 2^20 pulses
// - enter-init stops the counters and allows prescaler setting
// - every 2 source ticks outside init, shift pending and bypass, shadow copy and synced flag set
module rcr_calendar_regs
    import rcr_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              bkp_reset,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic [31:0]            hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              calendar_source_clock,
    input  wire logic              stamp_pin,
    input  wire rcr_pkg::rcr_cal_t cal_now,
    output rcr_pkg::rcr_cal_t      shadow_cal,
    output logic                   second_tick,
    output logic                   add_second,
    output logic                   alarm_occurred_flag
);
    import rcr_pkg::*;

    logic [1:0]  src_sync_q;
    logic        src_prev_q;
    logic [1:0]  stp_sync_q;
    logic        stp_prev_q;
    logic        wr_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rd_data;
    rcr_key_t    key_q;
    logic [31:0] ctl_q;
    logic        enter_init_bit;
    logic        init_state_flag;
    logic        shadow_synced_flag;
    logic        shift_pending_flag;
    logic        alarm_writable_flag;
    logic        timestamp_flag;
    logic        calibration_pending_flag;
    logic [6:0]  factor_a_q;
    logic [14:0] factor_s_q;
    logic [31:0] alarm_q;
    logic [6:0]  apre_cnt_q;
    logic [15:0] subsecond_counter;
    logic        add_one_second;
    logic [14:0] shift_fraction;
    logic        sync_cnt_q;
    logic        match_q;
    rcr_time_t   st_time_q;
    rcr_date_t   st_date_q;
    logic [15:0] st_ss_q;
    logic [15:0] cal_q;
    logic [15:0] cal_act_q;
    logic [19:0] cal_cnt_q;
    logic        extra_q;

    // source tick and stamp edge after two-stage synchronisers
    logic src_tick;
    logic stamp_evt;
    assign src_tick  = src_sync_q[1] & ~src_prev_q;
    assign stamp_evt = stp_sync_q[1] & ~stp_prev_q & ctl_q[`RCR_CTL_STAMP];

    always_ff @(posedge clk) begin
        src_sync_q <= {src_sync_q[0], calendar_source_clock};
        src_prev_q <= src_sync_q[1];
        stp_sync_q <= {stp_sync_q[0], stamp_pin};
        stp_prev_q <= stp_sync_q[1];
    end

    // address phase capture; only whole-word writes are kept
    always_ff @(posedge clk) begin
        if (reset | bkp_reset) begin
            wr_q      <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_q      <= hsel & htrans[1] & hready & hwrite & (hsize == 3'b010);
            wr_addr_q <= haddr[7:0];
        end
    end

    // zero-wait slave: read data taken at the address phase edge
    always_ff @(posedge clk) begin
        if (reset | bkp_reset) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= (hsel & htrans[1] & hready & ~hwrite) ? rd_data : 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // write strobes per register
    logic wr_ctl, wr_stat, wr_psc, wr_alm, wr_key, wr_sh, wr_cal;
    logic key_ok;
    assign wr_ctl  = wr_q & (wr_addr_q == `RCR_CTL_OFS);
    assign wr_stat = wr_q & (wr_addr_q == `RCR_STAT_OFS);
    assign wr_psc  = wr_q & (wr_addr_q == `RCR_PSC_OFS);
    assign wr_alm  = wr_q & (wr_addr_q == `RCR_ALM_OFS);
    assign wr_key  = wr_q & (wr_addr_q == `RCR_KEY_OFS);
    assign wr_sh   = wr_q & (wr_addr_q == `RCR_SHIFT_OFS);
    assign wr_cal  = wr_q & (wr_addr_q == `RCR_CAL_OFS);
    assign key_ok  = (key_q == KEY_OPEN);

    // key sequence; any wrong key locks again
    always_ff @(posedge clk) begin
        if (reset | bkp_reset) begin
            key_q <= KEY_LOCKED;
        end else if (wr_key) begin
            case (key_q)
                KEY_LOCKED: key_q <= (hwdata[7:0] == `RCR_KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
                KEY_HALF:   key_q <= (hwdata[7:0] == `RCR_KEY_SECOND) ? KEY_OPEN : KEY_LOCKED;
                KEY_OPEN:   key_q <= KEY_LOCKED;
                default:    key_q <= KEY_LOCKED;
            endcase
        end
    end

    // control: stamp enable, alarm enable, shadow bypass
    always_ff @(posedge clk) begin
        if (bkp_reset) begin
            ctl_q <= `RCR_ZERO_RST;
        end else if (wr_ctl & key_ok) begin
            ctl_q <= hwdata & 32'h00000920;
        end
    end

    // init request and init state; counters freeze while in init
    always_ff @(posedge clk) begin
        if (reset | bkp_reset) begin
            enter_init_bit  <= 1'b0;
            init_state_flag <= 1'b0;
        end else begin
            if (wr_stat & key_ok) begin
                enter_init_bit <= hwdata[`RCR_ST_ENTER_INIT_BIT];
            end
            if (~enter_init_bit) begin
                init_state_flag <= 1'b0;
            end else if (src_tick) begin
                init_state_flag <= 1'b1;
            end
        end
    end

    // alarm writable flag follows enable and init state
    always_ff @(posedge clk) begin
        if (bkp_reset) begin
            alarm_writable_flag <= 1'b0;
        end else begin
            alarm_writable_flag <= ~ctl_q[`RCR_CTL_ALMEN] | init_state_flag;
        end
    end

    // prescaler factors
    always_ff @(posedge clk) begin
        if (bkp_reset) begin
            factor_a_q <= 7'(`RCR_PSC_RST >> 16);
            factor_s_q <= 15'(`RCR_PSC_RST);
        end else if (wr_psc & key_ok & init_state_flag) begin
            factor_a_q <= hwdata[22:16];
            factor_s_q <= hwdata[14:0];
        end
    end

    // alarm register
    always_ff @(posedge clk) begin
        if (bkp_reset) begin
            alarm_q <= `RCR_ZERO_RST;
        end else if (wr_alm & key_ok & (init_state_flag | alarm_writable_flag)) begin
            alarm_q <= hwdata;
        end
    end

    // smooth calibration: effective mask count per window
    function automatic logic [8:0] eff_mask(input logic [15:0] c);
        logic [8:0] m;
        m = c[8:0];
        if (c[`RCR_CAL_W8]) begin
            m[1:0] = 2'b00;
        end else if (c[`RCR_CAL_W16]) begin
            m[0] = 1'b0;
        end
        return m;
    endfunction

    // stored calibration word: reserved bits dropped, stuck mask bits forced
    function automatic logic [15:0] cal_word(input logic [31:0] d);
        return {d[15:13], 4'h0, eff_mask(d[15:0])};
    endfunction

    logic win_end;
    logic mask_now;
    logic tick_eff;
    always_comb begin
        if (cal_act_q[`RCR_CAL_W8]) begin
            win_end = &cal_cnt_q[17:0];
        end else if (cal_act_q[`RCR_CAL_W16]) begin
            win_end = &cal_cnt_q[18:0];
        end else begin
            win_end = &cal_cnt_q;
        end
    end
    assign mask_now = (cal_cnt_q[10:0] == 11'h0) & (cal_cnt_q[19:11] < eff_mask(cal_act_q));
    assign tick_eff = (src_tick & ~mask_now) | extra_q;

    // calibration register, active copy and pending flag
    always_ff @(posedge clk) begin
        if (bkp_reset) begin
            cal_q                    <= 16'h0;
            cal_act_q                <= 16'h0;
            calibration_pending_flag <= 1'b0;
        end else begin
            if (wr_cal & key_ok) begin
                cal_q <= cal_word(hwdata);
            end
            if (wr_cal & key_ok & init_state_flag) begin
                cal_act_q <= cal_word(hwdata);
            end else if (src_tick & win_end) begin
                cal_act_q <= cal_q;
            end
            if (wr_cal & key_ok & ~init_state_flag) begin
                calibration_pending_flag <= 1'b1;
            end else if (src_tick & win_end) begin
                calibration_pending_flag <= 1'b0;
            end
        end
    end

    // 2^20 cycle count and pulse insertion every 2^11 pulses
    always_ff @(posedge clk) begin
        if (bkp_reset) begin
            cal_cnt_q <= 20'h0;
            extra_q   <= 1'b0;
        end else begin
            if (src_tick) begin
                cal_cnt_q <= cal_cnt_q + 20'h1;
            end
            extra_q <= src_tick & cal_act_q[`RCR_CAL_FREQUENCY_INCREASE] & (cal_cnt_q[10:0] == `RCR_INS_SLOT);
        end
    end

    // asynchronous prescaler stage
    logic apre_tick;
    logic shift_apply;
    assign apre_tick   = tick_eff & (apre_cnt_q == 7'h0) & ~init_state_flag;
    assign shift_apply = apre_tick & shift_pending_flag;
    always_ff @(posedge clk) begin
        if (bkp_reset) begin
            apre_cnt_q <= 7'h0;
        end else if (init_state_flag) begin
            apre_cnt_q <= factor_a_q;
        end else if (tick_eff) begin
            apre_cnt_q <= (apre_cnt_q == 7'h0) ? factor_a_q : apre_cnt_q - 7'h1;
        end
    end

    // synchronous down-counter, shift add and second tick
    always_ff @(posedge clk) begin
        if (bkp_reset | (reset & ~ctl_q[`RCR_CTL_BYPASS])) begin
            subsecond_counter <= 16'h0;
        end else if (init_state_flag) begin
            subsecond_counter <= {1'b0, factor_s_q};
        end else if (shift_apply) begin
            subsecond_counter <= subsecond_counter + {1'b0, shift_fraction};
        end else if (apre_tick) begin
            subsecond_counter <= (subsecond_counter == 16'h0) ? {1'b0, factor_s_q}
                                 : subsecond_counter - 16'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset | bkp_reset) begin
            second_tick <= 1'b0;
            add_second  <= 1'b0;
        end else begin
            second_tick <= apre_tick & ~shift_pending_flag & (subsecond_counter == 16'h0);
            add_second  <= shift_apply & add_one_second;
        end
    end

    // shift control write and pending flag
    always_ff @(posedge clk) begin
        if (bkp_reset) begin
            shift_pending_flag <= 1'b0;
            add_one_second     <= 1'b0;
            shift_fraction     <= 15'h0;
        end else if (wr_sh & key_ok & ~shift_pending_flag) begin
            shift_pending_flag <= 1'b1;
            add_one_second     <= hwdata[`RCR_SH_A1S];
            shift_fraction     <= hwdata[14:0];
        end else if (shift_apply) begin
            shift_pending_flag <= 1'b0;
        end
    end

    // shadow copy every two source ticks and synced flag
    logic sync_set;
    logic sync_clr;
    assign sync_set = src_tick & (sync_cnt_q == `RCR_SYNC_TICKS) & ~init_state_flag
                      & ~shift_pending_flag & ~ctl_q[`RCR_CTL_BYPASS];
    assign sync_clr = init_state_flag | shift_pending_flag | ctl_q[`RCR_CTL_BYPASS]
                      | wr_sh | (wr_stat & key_ok & ~hwdata[`RCR_ST_SYNC]);
    always_ff @(posedge clk) begin
        if (reset | bkp_reset) begin
            sync_cnt_q         <= 1'b0;
            shadow_synced_flag <= 1'b0;
            shadow_cal         <= '0;
        end else begin
            if (src_tick) begin
                sync_cnt_q <= ~sync_cnt_q;
            end
            if (sync_set) begin
                shadow_synced_flag <= 1'b1;
                shadow_cal         <= cal_now;
            end else if (sync_clr) begin
                shadow_synced_flag <= 1'b0;
            end
        end
    end

    // alarm compare against the running calendar
    function automatic logic alarm_hit(input logic [31:0] a, input rcr_cal_t c);
        logic d;
        logic h;
        logic m;
        logic s;
        d = a[`RCR_AL_WDSEL] ? (a[26:24] == c.date.weekday_field)
                             : (a[29:24] == {c.date.day_tens, c.date.day_units});
        h = (a[22:16] == {c.time_of_day.pm, c.time_of_day.hour_tens,
                          c.time_of_day.hour_units});
        m = (a[14:8] == {c.time_of_day.minute_tens, c.time_of_day.minute_units});
        s = (a[6:0] == {c.time_of_day.second_tens, c.time_of_day.second_units});
        return (a[`RCR_AL_DAY_FIELD_MASK] | d) & (a[`RCR_AL_HOUR_FIELD_MASK] | h)
             & (a[`RCR_AL_MINUTE_FIELD_MASK] | m) & (a[`RCR_AL_SECOND_FIELD_MASK] | s);
    endfunction

    logic match_now;
    assign match_now = ctl_q[`RCR_CTL_ALMEN] & alarm_hit(alarm_q, cal_now);
    always_ff @(posedge clk) begin
        if (bkp_reset) begin
            match_q             <= 1'b0;
            alarm_occurred_flag <= 1'b0;
        end else begin
            match_q <= match_now;
            if (match_now & ~match_q) begin
                alarm_occurred_flag <= 1'b1;
            end else if (wr_stat & ~hwdata[`RCR_ST_ALMF]) begin
                alarm_occurred_flag <= 1'b0;
            end
        end
    end

    // time stamp flag and capture; a new event wins over a clear
    logic ts_clr;
    assign ts_clr = wr_stat & ~hwdata[`RCR_ST_TSF];
    always_ff @(posedge clk) begin
        if (bkp_reset) begin
            timestamp_flag <= 1'b0;
            st_time_q      <= '0;
            st_date_q      <= '0;
            st_ss_q        <= 16'h0;
        end else if (stamp_evt) begin
            timestamp_flag <= 1'b1;
            st_time_q      <= cal_now.time_of_day;
            st_date_q      <= cal_now.date;
            st_ss_q        <= subsecond_counter;
        end else if (ts_clr) begin
            timestamp_flag <= 1'b0;
            st_time_q      <= '0;
            st_date_q      <= '0;
            st_ss_q        <= 16'h0;
        end
    end

    // read mux; write-only and unmapped words read zero
    always_comb begin
        case (haddr[7:0])
            `RCR_CTL_OFS:  rd_data = ctl_q;
            `RCR_STAT_OFS: rd_data = {15'h0, calibration_pending_flag, 4'h0, timestamp_flag,
                                      2'h0, alarm_occurred_flag, enter_init_bit,
                                      init_state_flag, shadow_synced_flag, 1'b0,
                                      shift_pending_flag, 2'h0, alarm_writable_flag};
            `RCR_PSC_OFS:  rd_data = {9'h0, factor_a_q, 1'b0, factor_s_q};
            `RCR_ALM_OFS:  rd_data = alarm_q;
            `RCR_SS_OFS:   rd_data = {16'h0, subsecond_counter};
            `RCR_TST_OFS:  rd_data = {9'h0, st_time_q[20:14], 1'b0, st_time_q[13:7],
                                      1'b0, st_time_q[6:0]};
            `RCR_TSD_OFS:  rd_data = {16'h0, st_date_q[13:6], 2'b0, st_date_q[5:0]};
            `RCR_TSS_OFS:  rd_data = {16'h0, st_ss_q};
            `RCR_CAL_OFS:  rd_data = {16'h0, cal_q};
            default:       rd_data = 32'h0;
        endcase
    end
endmodule
`default_nettype wire

// ==== rcr_defines.svh ====
// register offsets, field positions, reset values and counts of the
// calendar register block; assumes a 32-bit word-wide bus slave
`ifndef RCR_DEFINES_SVH
`define RCR_DEFINES_SVH
`define RCR_CTL_OFS    8'h08
`define RCR_STAT_OFS   8'h0c
`define RCR_PSC_OFS    8'h10
`define RCR_ALM_OFS    8'h1c
`define RCR_KEY_OFS    8'h24
`define RCR_SS_OFS     8'h28
`define RCR_SHIFT_OFS  8'h2c
`define RCR_TST_OFS    8'h30
`define RCR_TSD_OFS    8'h34
`define RCR_TSS_OFS    8'h38
`define RCR_CAL_OFS    8'h3c
`define RCR_PSC_RST    32'h007f00ff
`define RCR_ZERO_RST   32'h00000000
// key values are arbitrary
`define RCR_KEY_FIRST  8'hc5
`define RCR_KEY_SECOND 8'h3a
// control fields
`define RCR_CTL_STAMP  11
`define RCR_CTL_ALMEN  8
`define RCR_CTL_BYPASS 5
// status fields
`define RCR_ST_CALP    16
`define RCR_ST_TSF     11
`define RCR_ST_ALMF    8
`define RCR_ST_ENTER_INIT_BIT   7
`define RCR_ST_SYNC    5
// alarm fields
`define RCR_AL_DAY_FIELD_MASK    31
`define RCR_AL_WDSEL   30
`define RCR_AL_HOUR_FIELD_MASK    23
`define RCR_AL_MINUTE_FIELD_MASK    15
`define RCR_AL_SECOND_FIELD_MASK    7
// shift and calibration fields
`define RCR_SH_A1S     31
`define RCR_CAL_FREQUENCY_INCREASE  15
`define RCR_CAL_W8     14
`define RCR_CAL_W16    13
// sync copies when the two-tick toggle counter equals this value
`define RCR_SYNC_TICKS 1'b1
`define RCR_INS_SLOT   11'h400
`endif

// ==== rcr_pkg.sv ====
// types shared by the calendar register block
// assumes calendar fields are BCD
package rcr_pkg;
    typedef struct packed {
        logic       pm;
        logic [1:0] hour_tens;
        logic [3:0] hour_units;
        logic [2:0] minute_tens;
        logic [3:0] minute_units;
        logic [2:0] second_tens;
        logic [3:0] second_units;
    } rcr_time_t;
    typedef struct packed {
        logic [2:0] weekday_field;
        logic       month_tens;
        logic [3:0] month_units;
        logic [1:0] day_tens;
        logic [3:0] day_units;
    } rcr_date_t;
    typedef struct packed {
        rcr_date_t date;
        rcr_time_t time_of_day;
    } rcr_cal_t;
    typedef enum logic [2:0] {
        KEY_LOCKED = 3'b001,
        KEY_HALF   = 3'b010,
        KEY_OPEN   = 3'b100
    } rcr_key_t;
endpackage

// ==== testbench.sv ====
// register level test of the calendar register block over AHB-Lite
// assumes the monitor is bound in and the source clock is made here
`timescale 1ns/10ps
`default_nettype none
`include "rcr_defines.svh"
module testbench;
    import rcr_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        bkp_reset = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        calendar_source_clock = 1'b0;
    logic [2:0]  src_cnt = 3'h0;
    logic        stamp_pin = 1'b0;
    rcr_cal_t    cal_now = '0;
    logic        second_tick;
    logic        add_second;
    logic        alarm_occurred_flag;
    logic [31:0] q;
    int          n;
    int          adds = 0;
    int          cycles = 0;
    int          num_errors = 0;
    int          n_tests = 0;
    assign hready = hreadyout;
    rcr_calendar_regs u_dut (.clk(clk), .reset(reset), .bkp_reset(bkp_reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .calendar_source_clock(calendar_source_clock), .stamp_pin(stamp_pin),
        .cal_now(cal_now), .shadow_cal(), .second_tick(second_tick),
        .add_second(add_second), .alarm_occurred_flag(alarm_occurred_flag));
    always #20 clk = ~clk;
    // source clock at one eighth of the bus clock, pulse count, hang limit
    always @(posedge clk) begin
        src_cnt <= src_cnt + 3'h1;
        calendar_source_clock <= src_cnt[2];
        cycles <= cycles + 1;
        if (add_second === 1'b1)
            adds <= adds + 1;
        if (cycles == 30000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic summarize();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one word transfer, called just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        logic rdy;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        do begin
            @(negedge clk);
            rdy = hready;
            @(posedge clk);
        end while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(negedge clk);
            rdy = hready;
            r = hrdata;
            @(posedge clk);
        end while (rdy !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
        @(posedge clk); // gap so a following read sees the new value
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
        xfer(1'b0, a, 32'h0, q);
        for (int i = 0; i < 80 && q[b] !== v; i++)
            xfer(1'b0, a, 32'h0, q);
        chk({31'h0, q[b]}, {31'h0, v});
    endtask
    task automatic wait_tick(output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (second_tick !== 1'b1 && k < 600);
    endtask
    task automatic flag_chk(input logic exp);
        repeat (4) @(negedge clk);
        chk({31'h0, alarm_occurred_flag}, {31'h0, exp});
        @(posedge clk);
    endtask
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        bkp_reset <= 1'b0;
        rdc(`RCR_PSC_OFS, `RCR_PSC_RST);
        rdc(`RCR_ALM_OFS, 32'h0);
        rdc(`RCR_SS_OFS, 32'h0);
        rdc(`RCR_TSS_OFS, 32'h0);
        rdc(`RCR_CAL_OFS, 32'h0);
        rdc(8'h40, 32'h0);
        wr(`RCR_PSC_OFS, 32'h00030007);
        rdc(`RCR_PSC_OFS, `RCR_PSC_RST);
        wr(`RCR_KEY_OFS, {24'h0, `RCR_KEY_FIRST});
        wr(`RCR_KEY_OFS, {24'h0, `RCR_KEY_SECOND});
        wr(`RCR_STAT_OFS, 32'h80);
        wait_bit(`RCR_STAT_OFS, 6, 1'b1);
        wr(`RCR_PSC_OFS, 32'h00030007);
        rdc(`RCR_PSC_OFS, 32'h00030007);
        wr(`RCR_ALM_OFS, 32'h80803456);
        rdc(`RCR_ALM_OFS, 32'h80803456);
        wr(`RCR_CAL_OFS, 32'h0000c1ff);
        rdc(`RCR_CAL_OFS, 32'h0000c1fc);
        wr(`RCR_CAL_OFS, 32'h0000a003);
        rdc(`RCR_CAL_OFS, 32'h0000a002);
        wr(`RCR_CAL_OFS, 32'h0);
        wr(`RCR_STAT_OFS, 32'h0);
        wr(`RCR_CAL_OFS, 32'h0);
        wait_bit(`RCR_STAT_OFS, 16, 1'b1);
        wait_tick(n);
        wait_tick(n);
        chk(32'(n), 32'h100);
        @(posedge clk);
        wr(`RCR_CTL_OFS, 32'h100);
        wait_bit(`RCR_STAT_OFS, 0, 1'b0);
        cal_now.time_of_day <= {1'b0, 2'h1, 4'h2, 3'h3, 4'h4, 3'h5, 4'h7};
        flag_chk(1'b0);
        cal_now.time_of_day.second_units <= 4'h6;
        flag_chk(1'b1);
        wr(`RCR_STAT_OFS, 32'h0);
        flag_chk(1'b0);
        wr(`RCR_CTL_OFS, 32'h900);
        cal_now.date <= {3'h5, 1'h1, 4'h2, 2'h3, 4'h1};
        stamp_pin <= 1'b1;
        repeat (4) @(posedge clk);
        stamp_pin <= 1'b0;
        wait_bit(`RCR_STAT_OFS, 11, 1'b1);
        wr(`RCR_TST_OFS, 32'hffffffff);
        rdc(`RCR_TST_OFS, 32'h00123456);
        rdc(`RCR_TSD_OFS, 32'h0000b231);
        wr(`RCR_STAT_OFS, 32'h0);
        rdc(`RCR_TST_OFS, 32'h0);
        rdc(`RCR_TSD_OFS, 32'h0);
        rdc(`RCR_TSS_OFS, 32'h0);
        wr(`RCR_SHIFT_OFS, 32'h80000002);
        xfer(1'b0, `RCR_STAT_OFS, 32'h0, q);
        chk({31'h0, q[3]}, 32'h1);
        chk({31'h0, q[5]}, 32'h0);
        wait_bit(`RCR_STAT_OFS, 3, 1'b0);
        chk(32'(adds), 32'h1);
        summarize();
    end
endmodule
`default_nettype wire
